// File: rtl/cg_bank_one_params.svh
// register offsets, field positions and reset values of the deep-sleep gating bank
// assumes inclusion from the design, checker and bench files
`ifndef CG_BANK_ONE_PARAMS_SVH
`define CG_BANK_ONE_PARAMS_SVH
`define DS_GATE_OFFSET 12'h124
`define DS_GATE_RESET 32'h00000000
`define DS_GATE_IMPL_MASK 32'h010f0111
`define RUN_GATE_OFFSET 12'h300
`define SLEEP_GATE_OFFSET 12'h304
`define RUN_CFG_OFFSET 12'h308
`define IRQ_STATUS_OFFSET 12'h30c
`define IRQ_MASK_OFFSET 12'h310
`define GATE_STATE_OFFSET 12'h314
`define RUN_CFG_AUTO_BIT 0
`define FIELD_ANALOG_COMPARATOR_ZERO_GATE 24
`define FIELD_GPC3 19
`define FIELD_GPC2 18
`define FIELD_GPC1 17
`define FIELD_GPC0 16
`define FIELD_QDEC0 8
`define FIELD_SSER0 4
`define FIELD_ASER0 0
`define IRQ_FAULT_BIT 0
`define IRQ_UNMAPPED_BIT 1
`endif

// File: rtl/cg_bank_one_pkg.sv
// types for the deep-sleep unit clock gating bank
// assumes nothing beyond the params header
package cg_bank_one_pkg;
   typedef enum logic [1:0] {
      pwr_run = 2'b00,
      pwr_sleep = 2'b01,
      pwr_deep_sleep = 2'b10
   } power_mode_e;
   typedef logic [31:0] word_t;
endpackage

// File: rtl/deep_sleep_clock_gate_bank_one.sv
// unit clock gate control for eight peripheral units, with fault on access to gated units
// assumes a plain single-cycle register port and a peripheral access port on the same clock
`timescale 1ns/1ns
`include "cg_bank_one_params.svh"

// Function
// - each implemented enable bit drives the clock gate of exactly one unit
// - peripheral access to a unit whose clock is gated returns a bus fault
// - reset clears the gating register to all zeros
// - deep-sleep register at 0x124; run and sleep companions share its layout
// - sleep and deep-sleep registers act only when auto gating is set
// - bits 19 to 16 enable counters three down to zero
// - bit 8 enables quadrature decoder zero
// - bit 4 enables synchronous serial port zero
// - bit 0 enables asynchronous serial port zero
// - reserved bits read zero; software preserves them on read-modify-write
// - positions without a unit are non-functional reserved bits
module deep_sleep_clock_gate_bank_one
   import cg_bank_one_pkg::*;
#(
   parameter int UNITS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic [1:0] power_mode,
   input wire logic periph_req,
   input wire logic [2:0] periph_unit,
   output logic periph_grant,
   output logic periph_fault,
   output logic [UNITS-1:0] unit_clk_en,
   output logic irq
);

   // ***********************************************
   // field map: unit index to register bit
   // ***********************************************
   localparam int unsigned FIELD_POS [8] = '{`FIELD_ASER0, `FIELD_SSER0, `FIELD_QDEC0,
      `FIELD_GPC0, `FIELD_GPC1, `FIELD_GPC2, `FIELD_GPC3, `FIELD_ANALOG_COMPARATOR_ZERO_GATE};

   word_t deep_sleep_unit_clock_gate_one;
   word_t run_unit_clock_gate_one;
   word_t sleep_unit_clock_gate_one;
   logic auto_gating_select;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   word_t next_rdata;
   word_t active_gate;
   logic hit;
   logic [UNITS-1:0] next_clk_en;
   logic fault_evt;
   logic unmapped_evt;

   // ***********************************************
   // register writes
   // ***********************************************
   // reserved positions are masked at write so they hold zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         deep_sleep_unit_clock_gate_one <= `DS_GATE_RESET;
      end else if (reg_write && reg_addr == `DS_GATE_OFFSET) begin
         deep_sleep_unit_clock_gate_one <= reg_wdata & `DS_GATE_IMPL_MASK;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_unit_clock_gate_one <= `DS_GATE_RESET;
         sleep_unit_clock_gate_one <= `DS_GATE_RESET;
      end else if (reg_write) begin
         if (reg_addr == `RUN_GATE_OFFSET) begin
            run_unit_clock_gate_one <= reg_wdata & `DS_GATE_IMPL_MASK;
         end
         if (reg_addr == `SLEEP_GATE_OFFSET) begin
            sleep_unit_clock_gate_one <= reg_wdata & `DS_GATE_IMPL_MASK;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         auto_gating_select <= 1'b0;
         irq_mask <= 2'h0;
      end else if (reg_write) begin
         if (reg_addr == `RUN_CFG_OFFSET) begin
            auto_gating_select <= reg_wdata[`RUN_CFG_AUTO_BIT];
         end
         if (reg_addr == `IRQ_MASK_OFFSET) begin
            irq_mask <= reg_wdata[1:0];
         end
      end
   end

   // ***********************************************
   // gate source selection
   // ***********************************************
   always_comb begin
      active_gate = run_unit_clock_gate_one;
      if (auto_gating_select) begin
         if (power_mode == pwr_deep_sleep) begin
            active_gate = deep_sleep_unit_clock_gate_one;
         end else if (power_mode == pwr_sleep) begin
            active_gate = sleep_unit_clock_gate_one;
         end
      end
   end

   // one enable per unit; unused positions never reach a gate
   genvar g;
   generate
      for (g = 0; g < UNITS; g++) begin : gen_gate
         assign next_clk_en[g] = active_gate[FIELD_POS[g]];
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unit_clk_en <= '0;
      end else begin
         unit_clk_en <= next_clk_en;
      end
   end

   // ***********************************************
   // peripheral access check
   // ***********************************************
   // checked against the live selection so a just-written enable counts
   assign fault_evt = periph_req && !next_clk_en[periph_unit];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         periph_grant <= 1'b0;
         periph_fault <= 1'b0;
      end else begin
         periph_grant <= periph_req && next_clk_en[periph_unit];
         periph_fault <= fault_evt;
      end
   end

   // ***********************************************
   // register reads and interrupt
   // ***********************************************
   always_comb begin
      hit = 1'b1;
      next_rdata = '0;
      unique case (reg_addr)
         `DS_GATE_OFFSET: next_rdata = deep_sleep_unit_clock_gate_one;
         `RUN_GATE_OFFSET: next_rdata = run_unit_clock_gate_one;
         `SLEEP_GATE_OFFSET: next_rdata = sleep_unit_clock_gate_one;
         `RUN_CFG_OFFSET: next_rdata[`RUN_CFG_AUTO_BIT] = auto_gating_select;
         `IRQ_STATUS_OFFSET: next_rdata[1:0] = irq_status;
         `IRQ_MASK_OFFSET: next_rdata[1:0] = irq_mask;
         `GATE_STATE_OFFSET: next_rdata[UNITS-1:0] = unit_clk_en;
         default: hit = 1'b0;
      endcase
   end

   assign unmapped_evt = (reg_read || reg_write) && !hit;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_read ? next_rdata : '0;
      end
   end

   // a new event in the clearing read's cycle stays set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (i == `IRQ_FAULT_BIT ? fault_evt : unmapped_evt) begin
               irq_status[i] <= 1'b1;
            end else if (reg_read && reg_addr == `IRQ_STATUS_OFFSET) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

endmodule

// File: verification/deep_sleep_clock_gate_bank_one_properties.sv
// port checker for the deep-sleep unit clock gating bank
// assumes a bind onto the top module, one clock and an async high reset
`timescale 1ns/1ns
`include "cg_bank_one_params.svh"
module deep_sleep_clock_gate_bank_one_properties
   import cg_bank_one_pkg::*;
#(
   parameter int UNITS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic [1:0] power_mode,
   input wire logic periph_req,
   input wire logic [2:0] periph_unit,
   input wire logic periph_grant,
   input wire logic periph_fault,
   input wire logic [UNITS-1:0] unit_clk_en,
   input wire logic irq
);
   // ****************
   // assertions
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_answer_next: assert property (periph_req |=> periph_grant != periph_fault)
      else $error("no single answer after access");
   a_no_stray: assert property (!periph_req |=> !periph_grant && !periph_fault)
      else $error("answer without access");
   a_fault_gated: assert property (periph_req |=> periph_fault == !unit_clk_en[$past(periph_unit)])
      else $error("fault does not match gate");
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   a_reserved_zero: assert property (reg_read && reg_addr == `DS_GATE_OFFSET |=>
      (reg_rdata & ~`DS_GATE_IMPL_MASK) == 32'h0) else $error("reserved bits read nonzero");
   a_state_read: assert property (reg_read && reg_addr == `GATE_STATE_OFFSET |=>
      reg_rdata == 32'($past(unit_clk_en))) else $error("gate state read wrong");
   // gates move only two cycles after a write or one after a mode change
   a_gate_stable: assert property (!reg_write ##1 $stable(power_mode) |=> $stable(unit_clk_en))
      else $error("gate changed without cause");
   a_answer_excl: assert property (!(periph_grant && periph_fault))
      else $error("grant and fault together");
   c_fault: cover property (periph_fault);
   c_grant: cover property (periph_grant);
   c_irq: cover property (irq);
endmodule

// File: verification/test_deep_sleep_clock_gate_bank_one.sv
// self-checking bench for the deep-sleep unit clock gating bank
// assumes design, package and checker compiled before this file
`timescale 1ns/1ns
`include "cg_bank_one_params.svh"
bind deep_sleep_clock_gate_bank_one deep_sleep_clock_gate_bank_one_properties #(.UNITS(UNITS))
   i_props (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .power_mode(power_mode),
   .periph_req(periph_req), .periph_unit(periph_unit), .periph_grant(periph_grant),
   .periph_fault(periph_fault), .unit_clk_en(unit_clk_en), .irq(irq));
module test_deep_sleep_clock_gate_bank_one
   import cg_bank_one_pkg::*;
;
   // ****************
   // stimulus and checks
   // ****************
   logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, periph_req = 0;
   logic [11:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata;
   logic [1:0] power_mode = pwr_run;
   logic [2:0] periph_unit = 0;
   logic periph_grant, periph_fault, irq;
   logic [7:0] unit_clk_en;
   int errors = 0, n_checks = 0, i;
   always #50 clk = ~clk;
   deep_sleep_clock_gate_bank_one #(.UNITS(8)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .power_mode(power_mode), .periph_req(periph_req), .periph_unit(periph_unit),
      .periph_grant(periph_grant), .periph_fault(periph_fault), .unit_clk_en(unit_clk_en),
      .irq(irq));
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task settle;
      @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk("rdata", reg_rdata, exp);
   endtask
   task automatic mode(logic [1:0] m);
      @(posedge clk);
      power_mode <= m;
      settle();
   endtask
   task automatic preq(logic [2:0] u, logic f);
      @(posedge clk);
      periph_req <= 1'b1;
      periph_unit <= u;
      @(posedge clk);
      periph_req <= 1'b0;
      #1;
      chk("fault", periph_fault, f);
      chk("grant", periph_grant, !f);
   endtask
   function automatic int pos(int k);
      return k == 7 ? 24 : k > 2 ? 13 + k : 4 * k;
   endfunction
   task t_reset;
      settle();
      chk("clk_en", unit_clk_en, 0);
      rd(`DS_GATE_OFFSET, `DS_GATE_RESET);
   endtask
   task t_units;
      wr(`RUN_CFG_OFFSET, 32'h1);
      mode(pwr_deep_sleep);
      wr(`DS_GATE_OFFSET, 32'hffffffff);
      rd(`DS_GATE_OFFSET, `DS_GATE_IMPL_MASK);
      for (i = 0; i < 8; i++) begin
         wr(`DS_GATE_OFFSET, 32'h1 << pos(i));
         settle();
         chk("clk_en", unit_clk_en, 32'h1 << i);
         preq(i[2:0], 1'b0);
         preq(3'(i + 1), 1'b1);
      end
   endtask
   task t_select;
      wr(`SLEEP_GATE_OFFSET, 32'h1);
      mode(pwr_sleep);
      chk("clk_en", unit_clk_en, 32'h1);
      mode(pwr_deep_sleep);
      chk("clk_en", unit_clk_en, 32'h80);
      wr(`RUN_CFG_OFFSET, 32'h0);
      wr(`RUN_GATE_OFFSET, 32'h10);
      settle();
      chk("clk_en", unit_clk_en, 32'h2);
      rd(`GATE_STATE_OFFSET, 32'h2);
   endtask
   task t_irq;
      wr(`IRQ_MASK_OFFSET, 32'h1);
      settle();
      chk("irq", irq, 1);
      wr(`IRQ_MASK_OFFSET, 32'h2);
      settle();
      chk("irq", irq, 0);
      rd(`IRQ_STATUS_OFFSET, 32'h1);
      rd(12'h7fc, 32'h0);
      settle();
      chk("irq", irq, 1);
      rd(`IRQ_STATUS_OFFSET, 32'h2);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_units();
      t_select();
      t_irq();
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      t_reset();
      report_and_stop();
   end
   // limit well above the roughly 100 cycles the tests take
   initial begin
      #100000;
      errors++;
      report_and_stop();
   end
endmodule
